// ### sbp_pkg.sv
// Constants, pin map and command codes for the strobed bidirectional port host controller.
package sbp_pkg;
  localparam int CLK_NS = 100;
  localparam int T_RES_NS = 50000;
  localparam int T_RD_NS = 150;
  localparam int T_RDV_NS = 120;
  localparam int T_WR_NS = 100;
  localparam int T_RV_NS = 300;
  localparam int SYNC_STAGES = 3;
  localparam logic [9:0] RES_CYC = 10'((T_RES_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] RD_CYC = 10'((T_RD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] RD_CAP_CYC = 10'((T_RDV_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [9:0] WR_CYC = 10'((T_WR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] RV_CYC = 10'((T_RV_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] ADDR_PORT_A = 2'h0;
  localparam logic [1:0] ADDR_PORT_C = 2'h2;
  localparam logic [1:0] ADDR_CTRL = 2'h3;
  localparam logic [2:0] OP_SETUP = 3'h0;
  localparam logic [2:0] OP_WRITE_A = 3'h1;
  localparam logic [2:0] OP_READ_A = 3'h2;
  localparam logic [2:0] OP_READ_C = 3'h3;
  localparam logic [2:0] OP_BIT_CMD = 3'h4;
  localparam logic [2:0] OP_WRITE_C = 3'h5;
  localparam logic MODE_FLAG = 1'h1;
  localparam logic [1:0] MODE_UPPER_BIDIR = 2'h2;
  localparam int BIT_OUT_FULL_N = 7;
  localparam int BIT_OUT_EN = 6;
  localparam int BIT_IN_FULL = 5;
  localparam int BIT_IN_EN = 4;
  localparam int BIT_UPPER_IRQ = 3;
  localparam logic [2:0] POS_OUT_EN = 3'h6;
  localparam logic [2:0] POS_IN_EN = 3'h4;
  localparam logic [1:0] STEP_LAST_SETUP = 2'h2;

  function automatic logic [7:0] sbp_bit_cmd(input logic [2:0] pos, input logic val);
    sbp_bit_cmd = {1'h0, 3'h0, pos, val};
  endfunction
endpackage

// ### sbp_stream_if.sv
// Valid/ready byte stream carrier between the controller and its receive buffer.
`timescale 1ns/1ps
interface sbp_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### sbp_buf.sv
// Two-entry skid buffer for received bytes.
`timescale 1ns/1ps
module sbp_buf #(
  parameter int W = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  sbp_stream_if.snk in_s,
  sbp_stream_if.src out_s
);
  typedef struct packed {
    logic out_valid;
    logic [W-1:0] out_data;
    logic skid_valid;
    logic [W-1:0] skid_data;
  } sbp_buf_state_t;

  sbp_buf_state_t q;
  sbp_buf_state_t d;

  // A second entry lets a stalled receiver hold one byte while the next one lands.
  always_comb begin
    d = q;
    if (out_s.ready || !q.out_valid) begin
      if (q.skid_valid) begin
        // Ready was low in this cycle, so a waiting input word is taken only later.
        d.out_valid = 1'h1;
        d.out_data = q.skid_data;
        d.skid_valid = 1'h0;
      end else begin
        d.out_valid = in_s.valid;
        d.out_data = in_s.data;
      end
    end else if (in_s.valid && !q.skid_valid) begin
      d.skid_valid = 1'h1;
      d.skid_data = in_s.data;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_s.ready = !q.skid_valid;
  assign out_s.valid = q.out_valid;
  assign out_s.data = q.out_data;
endmodule

// ### sbp_host.sv
// Host controller that drives the peripheral interface's processor-side pins.
`timescale 1ns/1ps
module sbp_host (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_op_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic nodata_out,
  output logic [7:0] status_out,
  output logic input_full_out,
  output logic output_full_n_out,
  output logic irq_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic rx_ready_in,
  output logic dev_reset_out,
  output logic dev_cs_n_out,
  output logic dev_rd_n_out,
  output logic dev_wr_n_out,
  output logic [1:0] dev_addr_out,
  output logic [7:0] dev_data_out,
  output logic dev_data_oe_out,
  input wire logic [7:0] dev_data_in,
  input wire logic dev_irq_in
);
  typedef enum logic [5:0] {
    ST_RST = 6'h01,
    ST_IDLE = 6'h02,
    ST_SETUP = 6'h04,
    ST_STROBE = 6'h08,
    ST_HOLD = 6'h10,
    ST_RECOVER = 6'h20
  } sbp_st_t;

  typedef struct packed {
    sbp_st_t st;
    logic [2:0] op;
    logic [1:0] step;
    logic [7:0] cmd;
    logic [9:0] cnt;
    logic dev_reset;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic oe;
    logic [1:0] addr;
    logic [7:0] dout;
    logic [7:0] status;
    logic irq;
    logic nodata;
    logic ready;
    logic push;
    logic [7:0] pbyte;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic i1;
    logic i2;
    logic i3;
  } sbp_host_state_t;

  localparam sbp_host_state_t RST_STATE = '{st: ST_RST, op: 3'h0, step: 2'h0, cmd: 8'h00,
    cnt: 10'h000, dev_reset: 1'h1, cs_n: 1'h1, rd_n: 1'h1, wr_n: 1'h1, oe: 1'h0,
    addr: 2'h0, dout: 8'h00, status: 8'h00, irq: 1'h0, nodata: 1'h0, ready: 1'h0,
    push: 1'h0, pbyte: 8'h00, s1: 8'h00, s2: 8'h00, s3: 8'h00, i1: 1'h0, i2: 1'h0,
    i3: 1'h0};

  sbp_host_state_t q;
  sbp_host_state_t d;
  logic [10:0] acc;

  sbp_stream_if #(.W(8)) rx_in ();
  sbp_stream_if #(.W(8)) rx_out ();

  // One bus access per step: write flag, address, data.
  function automatic logic [10:0] sbp_access(input logic [2:0] op, input logic [1:0] step,
                                             input logic [7:0] cmd);
    sbp_access = {1'h0, sbp_pkg::ADDR_PORT_C, 8'h00};
    unique case (op)
      sbp_pkg::OP_SETUP: begin
        if (step == 2'h0) begin
          sbp_access = {1'h1, sbp_pkg::ADDR_CTRL, sbp_pkg::MODE_FLAG,
                        sbp_pkg::MODE_UPPER_BIDIR, 2'h0, cmd[2:0]};
        end else if (step == 2'h1) begin
          sbp_access = {1'h1, sbp_pkg::ADDR_CTRL,
                        sbp_pkg::sbp_bit_cmd(sbp_pkg::POS_OUT_EN, cmd[sbp_pkg::BIT_OUT_EN])};
        end else begin
          sbp_access = {1'h1, sbp_pkg::ADDR_CTRL,
                        sbp_pkg::sbp_bit_cmd(sbp_pkg::POS_IN_EN, cmd[sbp_pkg::BIT_IN_EN])};
        end
      end
      sbp_pkg::OP_WRITE_A: begin
        if (step != 2'h0) begin
          sbp_access = {1'h1, sbp_pkg::ADDR_PORT_A, cmd};
        end
      end
      sbp_pkg::OP_READ_A: begin
        if (step != 2'h0) begin
          sbp_access = {1'h0, sbp_pkg::ADDR_PORT_A, 8'h00};
        end
      end
      sbp_pkg::OP_BIT_CMD: begin
        sbp_access = {1'h1, sbp_pkg::ADDR_CTRL, sbp_pkg::sbp_bit_cmd(cmd[2:0], cmd[3])};
      end
      sbp_pkg::OP_WRITE_C: begin
        sbp_access = {1'h1, sbp_pkg::ADDR_PORT_C, cmd};
      end
      default: begin
        sbp_access = {1'h0, sbp_pkg::ADDR_PORT_C, 8'h00};
      end
    endcase
  endfunction

  always_comb begin
    d = q;
    acc = sbp_access(q.op, q.step, q.cmd);
    d.push = 1'h0;
    d.s1 = dev_data_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.i1 = dev_irq_in;
    d.i2 = q.i1;
    d.i3 = q.i2;
    if (q.i2 == q.i3) begin
      d.irq = q.i3;
    end
    unique case (q.st)
      ST_RST: begin
        d.cnt = q.cnt + 10'h001;
        if (q.cnt + 10'h001 >= sbp_pkg::RES_CYC) begin
          d.dev_reset = 1'h0;
          d.cnt = 10'h000;
          d.ready = 1'h1;
          d.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cmd_valid_in) begin
          d.op = cmd_op_in;
          d.cmd = cmd_data_in;
          d.step = 2'h0;
          d.nodata = 1'h0;
          d.ready = 1'h0;
          d.st = ST_SETUP;
        end
      end
      ST_SETUP: begin
        d.cs_n = 1'h0;
        d.addr = acc[9:8];
        d.dout = acc[7:0];
        d.oe = acc[10];
        d.wr_n = !acc[10];
        d.rd_n = acc[10];
        d.cnt = 10'h000;
        d.st = ST_STROBE;
      end
      ST_STROBE: begin
        d.cnt = q.cnt + 10'h001;
        if (!q.wr_n) begin
          if (q.cnt + 10'h001 >= sbp_pkg::WR_CYC) begin
            d.wr_n = 1'h1;
            d.st = ST_HOLD;
          end
        end else if (q.cnt + 10'h001 >= sbp_pkg::RD_CAP_CYC && q.s2 == q.s3) begin
          d.rd_n = 1'h1;
          if (q.addr == sbp_pkg::ADDR_PORT_C) begin
            d.status = q.s3;
          end else begin
            d.pbyte = q.s3;
          end
          d.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Data stays driven one cycle past the write strobe to give the device its hold time.
        d.cs_n = 1'h1;
        d.oe = 1'h0;
        d.cnt = 10'h000;
        d.st = ST_RECOVER;
      end
      ST_RECOVER: begin
        d.cnt = q.cnt + 10'h001;
        if (q.cnt + 10'h001 >= sbp_pkg::RV_CYC) begin
          d.cnt = q.cnt;
          d.st = ST_IDLE;
          d.ready = 1'h1;
          if (q.op == sbp_pkg::OP_SETUP && q.step != sbp_pkg::STEP_LAST_SETUP) begin
            d.step = q.step + 2'h1;
            d.ready = 1'h0;
            d.st = ST_SETUP;
          end else if (q.op == sbp_pkg::OP_READ_A && q.step == 2'h0) begin
            d.ready = 1'h0;
            if (!q.status[sbp_pkg::BIT_IN_FULL]) begin
              d.nodata = 1'h1;
              d.ready = 1'h1;
            end else if (rx_in.ready) begin
              d.step = 2'h1;
              d.st = ST_SETUP;
            end else begin
              d.st = ST_RECOVER;
            end
          end else if (q.op == sbp_pkg::OP_READ_A) begin
            d.push = 1'h1;
          end else if (q.op == sbp_pkg::OP_WRITE_A && q.step == 2'h0) begin
            // A full output latch is polled again rather than overwritten.
            d.ready = 1'h0;
            d.st = ST_SETUP;
            if (q.status[sbp_pkg::BIT_OUT_FULL_N]) begin
              d.step = 2'h1;
            end
          end
        end
      end
      default: begin
        d = RST_STATE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign rx_in.valid = q.push;
  assign rx_in.data = q.pbyte;
  assign rx_out.ready = rx_ready_in;

  sbp_buf #(.W(8)) u_buf (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .in_s(rx_in),
    .out_s(rx_out)
  );

  assign cmd_ready_out = q.ready;
  assign nodata_out = q.nodata;
  assign status_out = q.status;
  assign input_full_out = q.status[sbp_pkg::BIT_IN_FULL];
  assign output_full_n_out = q.status[sbp_pkg::BIT_OUT_FULL_N];
  assign irq_out = q.irq;
  assign rx_valid_out = rx_out.valid;
  assign rx_data_out = rx_out.data;
  assign dev_reset_out = q.dev_reset;
  assign dev_cs_n_out = q.cs_n;
  assign dev_rd_n_out = q.rd_n;
  assign dev_wr_n_out = q.wr_n;
  assign dev_addr_out = q.addr;
  assign dev_data_out = q.dout;
  assign dev_data_oe_out = q.oe;

  strobe_excl_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !(!q.rd_n && !q.wr_n)) else $error("read and write strobes low together");
  rd_width_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $fell(q.rd_n) |-> (!q.rd_n && !q.cs_n) [*5]) else $error("read strobe too short");
  strobe_gap_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ($rose(q.rd_n) || $rose(q.wr_n)) |-> (q.rd_n && q.wr_n) [*4])
    else $error("strobes too close");
  wr_drive_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !q.wr_n |-> q.oe ##1 q.oe) else $error("write data not driven through strobe");
  bit_cmd_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!q.wr_n && q.addr == sbp_pkg::ADDR_CTRL && q.step != 2'h0) |-> !q.dout[7])
    else $error("enable change not sent as single-bit command");
  mode_word_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!q.wr_n && q.addr == sbp_pkg::ADDR_CTRL && q.dout[7]) |->
    (q.dout[6:5] == sbp_pkg::MODE_UPPER_BIDIR && !q.op[2]))
    else $error("bad mode word");
  read_gate_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!q.rd_n && q.addr == sbp_pkg::ADDR_PORT_A) |-> q.status[sbp_pkg::BIT_IN_FULL])
    else $error("port read without input full");
  write_gate_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!q.wr_n && q.addr == sbp_pkg::ADDR_PORT_A) |-> q.status[sbp_pkg::BIT_OUT_FULL_N])
    else $error("port write while output full");
  setup_enables_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (q.op == sbp_pkg::OP_SETUP && q.st == ST_STROBE && q.step == 2'h2) |-> ##[1:8] q.ready)
    else $error("setup did not finish after enable command");
endmodule

// ### sbp_dev_model.sv
// Behavioural model of the peripheral interface device with its upper group bidirectional.
`timescale 1ns/1ps
module sbp_dev_model (
  input wire logic reset_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic irq_out,
  input wire logic stb_n_in,
  input wire logic ack_n_in,
  input wire logic [7:0] per_data_in,
  output logic [7:0] per_data_out,
  output logic per_oe_out
);
  logic [7:0] in_latch_q;
  logic [7:0] out_latch_q;
  logic [7:0] last_q;
  logic [7:0] rd_val;
  logic [7:0] status;
  logic ofn_q;
  logic out_en_q;
  logic in_full_q;
  logic in_en_q;
  logic reading;
  // Lower group bits read as zero; this model leaves the lower group unused.
  assign status = {ofn_q, out_en_q, in_full_q, in_en_q, irq_out, 3'h0};
  assign irq_out = (in_full_q & in_en_q & stb_n_in & rd_n_in) |
    (ofn_q & out_en_q & ack_n_in & wr_n_in);
  assign per_oe_out = !ack_n_in;
  assign per_data_out = out_latch_q;
  assign reading = !cs_n_in && !rd_n_in;
  assign rd_val = (addr_in == 2'h0) ? in_latch_q : ((addr_in == 2'h2) ? status : 8'h00);
  // A released bus shows the inverse of its last value so a late sample cannot pass.
  assign data_out = reading ? rd_val : ~last_q;
  always @* begin
    if (reading) begin
      last_q = rd_val;
    end
  end
  always @(posedge reset_in) begin
    ofn_q = 1'h1;
    in_full_q = 1'h0;
    out_en_q = 1'h0;
    in_en_q = 1'h0;
    last_q = 8'h00;
  end
  always @(posedge wr_n_in) begin
    if (!cs_n_in && !reset_in) begin
      if (addr_in == 2'h0) begin
        out_latch_q = data_in;
        ofn_q = 1'h0;
      end else if (addr_in == 2'h3 && data_in[7]) begin
        ofn_q = 1'h1;
        in_full_q = 1'h0;
        out_en_q = 1'h0;
        in_en_q = 1'h0;
      end else if (addr_in == 2'h3) begin
        case (data_in[3:1])
          3'h4: in_en_q = data_in[0];
          3'h5: in_full_q = data_in[0];
          3'h6: out_en_q = data_in[0];
          3'h7: ofn_q = data_in[0];
          default: ;
        endcase
      end
      // A whole-byte port C write reaches no handshake line or enable here.
    end
  end
  always @(posedge rd_n_in) begin
    if (!cs_n_in && addr_in == 2'h0) begin
      in_full_q = 1'h0;
    end
  end
  always @(negedge stb_n_in) begin
    in_latch_q = per_data_in;
    in_full_q = 1'h1;
  end
  always @(negedge ack_n_in) begin
    ofn_q = 1'h1;
  end
endmodule

// ### sbp_host_test.sv
// Self-checking bench for the host controller against a behavioural device.
`timescale 1ns/1ps
module sbp_host_test;
  typedef struct {logic [2:0] op; logic [7:0] arg; logic [7:0] exp;} sbp_row_t;
  logic ref_clk, rst, cmd_valid, cmd_ready, nodata, in_full, ofn, irq, rx_valid, rx_ready;
  logic [2:0] cmd_op;
  logic [7:0] cmd_data, status, rx_data, ddo, ddi, per_in, per_out;
  logic dreset, cs_n, rd_n, wr_n, doe, dirq, stb_n, ack_n, per_oe;
  logic [1:0] addr;
  int bad_count, comparisons, cycles;
  sbp_row_t rows [6] = '{'{sbp_pkg::OP_SETUP, 8'h00, 8'h80}, '{sbp_pkg::OP_SETUP, 8'h50, 8'hD8},
    '{sbp_pkg::OP_BIT_CMD, 8'h06, 8'h90}, '{sbp_pkg::OP_BIT_CMD, 8'h0E, 8'hD8},
    '{sbp_pkg::OP_WRITE_C, 8'hFF, 8'hD8}, '{sbp_pkg::OP_WRITE_A, 8'h5A, 8'h50}};
  sbp_host dut_u (.ref_clk_in(ref_clk), .rst_in(rst), .cmd_valid_in(cmd_valid),
    .cmd_op_in(cmd_op), .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready), .nodata_out(nodata),
    .status_out(status), .input_full_out(in_full), .output_full_n_out(ofn), .irq_out(irq),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_ready_in(rx_ready),
    .dev_reset_out(dreset), .dev_cs_n_out(cs_n), .dev_rd_n_out(rd_n), .dev_wr_n_out(wr_n),
    .dev_addr_out(addr), .dev_data_out(ddo), .dev_data_oe_out(doe), .dev_data_in(ddi),
    .dev_irq_in(dirq));
  sbp_dev_model dev_u (.reset_in(dreset), .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .addr_in(addr), .data_in(doe ? ddo : ~ddo), .data_out(ddi), .irq_out(dirq), .stb_n_in(stb_n),
    .ack_n_in(ack_n), .per_data_in(per_in), .per_data_out(per_out), .per_oe_out(per_oe));
  always #50 ref_clk = ~ref_clk;
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // The ceiling covers two 500-cycle device resets plus nineteen commands with margin.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (cmd_ready !== 1'b1) begin
      bad_count++;
    end
  endtask
  task automatic cmd(input logic [2:0] op, input logic [7:0] arg);
    wait_ready();
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = arg;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    @(posedge ref_clk);
    #1;
    wait_ready();
  endtask
  task automatic pulse_stb(input logic [7:0] v);
    per_in = v;
    @(posedge ref_clk);
    #1;
    stb_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    stb_n = 1'b1;
    @(posedge ref_clk);
    #1;
    per_in = ~v;
  endtask
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_data = 8'h00;
    rx_ready = 1'b0;
    stb_n = 1'b1;
    ack_n = 1'b1;
    per_in = 8'h00;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (12) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      cmd(rows[i].op, rows[i].arg);
      cmd(sbp_pkg::OP_READ_C, 8'h00);
      check(status, rows[i].exp);
    end
    check({7'h0, ofn}, 8'h00);
    ack_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    check({7'h0, per_oe}, 8'h01);
    check(per_out, 8'h5A);
    ack_n = 1'b1;
    @(posedge ref_clk);
    #1;
    check({7'h0, per_oe}, 8'h00);
    cmd(sbp_pkg::OP_READ_C, 8'h00);
    check(status, 8'hD8);
    check({7'h0, irq}, 8'h01);
    pulse_stb(8'hC3);
    cmd(sbp_pkg::OP_READ_C, 8'h00);
    check(status, 8'hF8);
    check({7'h0, in_full}, 8'h01);
    // Two bytes go in while the receiver stalls, so the buffer must hold both.
    cmd(sbp_pkg::OP_READ_A, 8'h00);
    pulse_stb(8'h3C);
    cmd(sbp_pkg::OP_READ_A, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1;
    check({7'h0, rx_valid}, 8'h01);
    check(rx_data, 8'hC3);
    rx_ready = 1'b1;
    @(posedge ref_clk);
    #1;
    check({7'h0, rx_valid}, 8'h01);
    check(rx_data, 8'h3C);
    @(posedge ref_clk);
    #1;
    check({7'h0, rx_valid}, 8'h00);
    rx_ready = 1'b0;
    cmd(sbp_pkg::OP_READ_C, 8'h00);
    check(status, 8'hD8);
    cmd(sbp_pkg::OP_READ_A, 8'h00);
    check({7'h0, nodata}, 8'h01);
    // A reset in mid-run must clear the enables again and hold the device in reset.
    rst = 1'b1;
    @(posedge ref_clk);
    #1;
    rst = 1'b0;
    check({dreset, cmd_ready, rx_valid, nodata, 4'h0}, 8'h80);
    check(status, 8'h00);
    cmd(sbp_pkg::OP_READ_C, 8'h00);
    check(status, 8'h80);
    check({7'h0, irq}, 8'h00);
    results();
  end
endmodule
